// ### hw/stop_restart_seq.v
// Stop, braking chain and power-on restart sequencer with an APB register slave.
// Notes on behaviour
// - stop mode 0 ramps down, 1 coasts immediately.
// - ramped stop follows the deceleration ramp, output ceases at stop speed.
// - coast stop disables output at once, no frequency control.
// - below-limit action ones: run at limit, stop, sleep; tens: coast, ramp.
// - below-limit action fires on set frequency falling through a nonzero lower limit.
// - braking only with nonzero braking start frequency, begins below it.
// - wait demag time, then short-circuit brake for its hold unless zero.
// - then DC brake for its time unless zero, then coast.
// - output blocked during the demagnetisation wait.
// - DC braking current is a percentage of rated current, 0 to 100 percent.
// - short-circuit current is a percentage of rated current, 0 to 150 percent.
// - zero braking frequency: below stop speed, wait stop delay, then determine.
// - detect mode 0 coasts directly; mode 1 coasts at once or after detect time.
// - detect mode 0 compares set speed, mode 1 feedback speed.
// - restart enabled and was running: resume after restart wait at power-on.
// - after run command, stay in standby for start delay before output.
// - acceptance 0: active run terminal at power-on ignored until re-asserted.
// - acceptance 1: active run terminal at power-on starts after initialisation.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`include "stop_seq_regs.vh"
module stop_restart_seq #(
   parameter TICK_CYCLES = `TICK_CYCLES,
   parameter TW = 20
) (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Drive side inputs
   input wire run_terminal,
   input wire [15:0] ramp_freq,
   input wire [15:0] feedback_freq,
   input wire [15:0] freq_lower_limit,
   input wire was_running_at_poweroff,
   // Power stage outputs
   output reg output_enable,
   output reg ramp_down,
   output reg short_brake_on,
   output reg dc_brake_on,
   output reg [11:0] brake_current,
   output reg sleep_req,
   output reg hold_at_limit,
   output reg running
);
   // ****************************************************************
   // State codes
   // ****************************************************************
   localparam S_IDLE = 4'd0;
   localparam S_START_DLY = 4'd1;
   localparam S_RUN = 4'd2;
   localparam S_DECEL = 4'd3;
   localparam S_DEMAG = 4'd4;
   localparam S_SHORT = 4'd5;
   localparam S_DCB = 4'd6;
   localparam S_SPD_DLY = 4'd7;
   localparam S_DETECT = 4'd8;
   localparam S_COAST = 4'd9;
   localparam S_PROTECT = 4'd10;
   localparam S_RESTART = 4'd11;
   localparam S_SLEEP = 4'd12;

   // ****************************************************************
   // Configuration registers
   // ****************************************************************
   reg stop_mode_select_q;
   reg stop_detect_mode_q;
   reg power_loss_restart_enable_q;
   reg terminal_poweron_run_accept_q;
   reg [7:0] below_limit_action_q;
   reg [15:0] stop_brake_start_freq_q;
   reg [TW-1:0] demag_wait_time_q;
   reg [TW-1:0] stop_dc_brake_time_q;
   reg [TW-1:0] short_brake_stop_hold_q;
   reg [11:0] stop_dc_brake_current_q;
   reg [11:0] short_brake_current_q;
   reg [15:0] stop_speed_threshold_q;
   reg [TW-1:0] stop_detect_time_q;
   reg [TW-1:0] stop_speed_delay_q;
   reg [TW-1:0] restart_wait_time_q;
   reg [TW-1:0] start_delay_time_q;
   reg [15:0] set_freq_q;
   reg run_cmd_q;
   reg stop_cmd_q;
   reg init_done_q;

   reg [3:0] state_q;
   reg [TW-1:0] timer_q;
   reg [31:0] tick_cnt_q;
   reg tick_q;
   reg [15:0] prev_set_q;
   reg term_prev_q;
   reg boot_q;

   wire wr = psel & penable & pwrite;
   wire rd_setup = psel & ~penable;
   wire bl_ramp = (below_limit_action_q[7:4] == 4'h1);

   // ****************************************************************
   // APB slave: no wait states, write on access phase.
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_mode_select_q <= 1'b0;
         stop_detect_mode_q <= 1'b0;
         power_loss_restart_enable_q <= 1'b0;
         terminal_poweron_run_accept_q <= 1'b0;
         below_limit_action_q <= `RST_BLA;
         stop_brake_start_freq_q <= 16'h0000;
         demag_wait_time_q <= {TW{1'b0}};
         stop_dc_brake_time_q <= {TW{1'b0}};
         short_brake_stop_hold_q <= {TW{1'b0}};
         stop_dc_brake_current_q <= `RST_DCB_CUR;
         short_brake_current_q <= `RST_SHORT_CUR;
         stop_speed_threshold_q <= `RST_STOP_SPEED;
         stop_detect_time_q <= `RST_DET_TIME;
         stop_speed_delay_q <= {TW{1'b0}};
         restart_wait_time_q <= `RST_RESTART_WAIT;
         start_delay_time_q <= {TW{1'b0}};
         set_freq_q <= 16'h0000;
         run_cmd_q <= 1'b0;
         stop_cmd_q <= 1'b0;
         init_done_q <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= rd_setup;
         pslverr <= 1'b0;
         run_cmd_q <= 1'b0;
         stop_cmd_q <= 1'b0;
         if (rd_setup) begin
            if (paddr == `OFS_CTRL) begin
               prdata <= {16'h0000, below_limit_action_q, 4'h0,
                          terminal_poweron_run_accept_q, power_loss_restart_enable_q,
                          stop_detect_mode_q, stop_mode_select_q};
            end else if (paddr == `OFS_BRAKE_FREQ) begin
               prdata <= {16'h0000, stop_brake_start_freq_q};
            end else if (paddr == `OFS_CURRENTS) begin
               prdata <= {4'h0, short_brake_current_q, 4'h0, stop_dc_brake_current_q};
            end else if (paddr == `OFS_STOP_SPEED) begin
               prdata <= {16'h0000, stop_speed_threshold_q};
            end else if (paddr == `OFS_FREQ_IN) begin
               prdata <= {16'h0000, set_freq_q};
            end else if (paddr == `OFS_STATUS) begin
               prdata <= {27'h0000000, init_done_q, state_q};
            end else begin
               prdata <= 32'h00000000;
            end
            if (paddr > `OFS_STATUS || paddr[1:0] != 2'b00) begin
               pslverr <= 1'b1;
            end
         end
         if (wr) begin
            if (paddr == `OFS_CTRL) begin
               stop_mode_select_q <= pwdata[`CTRL_STOP_MODE];
               stop_detect_mode_q <= pwdata[`CTRL_DET_MODE];
               power_loss_restart_enable_q <= pwdata[`CTRL_PLR_EN];
               terminal_poweron_run_accept_q <= pwdata[`CTRL_TERM_ACCEPT];
               below_limit_action_q <= pwdata[`CTRL_BLA_HI:`CTRL_BLA_LO];
            end else if (paddr == `OFS_BRAKE_FREQ) begin
               stop_brake_start_freq_q <= pwdata[15:0];
            end else if (paddr == `OFS_DEMAG) begin
               demag_wait_time_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_DCB_TIME) begin
               stop_dc_brake_time_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_SHORT_HOLD) begin
               short_brake_stop_hold_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_CURRENTS) begin
               stop_dc_brake_current_q <= pwdata[11:0];
               short_brake_current_q <= pwdata[27:16];
            end else if (paddr == `OFS_STOP_SPEED) begin
               stop_speed_threshold_q <= pwdata[15:0];
            end else if (paddr == `OFS_DET_TIME) begin
               stop_detect_time_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_SPD_DELAY) begin
               stop_speed_delay_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_RESTART_WAIT) begin
               restart_wait_time_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_START_DELAY) begin
               start_delay_time_q <= pwdata[TW-1:0];
            end else if (paddr == `OFS_FREQ_IN) begin
               set_freq_q <= pwdata[15:0];
            end else if (paddr == `OFS_CMD) begin
               run_cmd_q <= pwdata[`CMD_RUN];
               stop_cmd_q <= pwdata[`CMD_STOP];
               if (pwdata[`CMD_INIT_DONE]) begin
                  init_done_q <= 1'b1;
               end
            end
         end
      end
   end

   // ****************************************************************
   // 10 ms tick shared by every timer.
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q == TICK_CYCLES - 1) begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h00000001;
         tick_q <= 1'b0;
      end
   end

   // ****************************************************************
   // Sequencer
   // ****************************************************************
   wire det_speed_low = stop_detect_mode_q ? (feedback_freq < stop_speed_threshold_q)
                        : (set_freq_q < stop_speed_threshold_q);
   wire below_edge = (freq_lower_limit != 16'h0000) && (prev_set_q >= freq_lower_limit)
                     && (set_freq_q < freq_lower_limit);
   wire term_rise = run_terminal & ~term_prev_q;
   wire run_req = run_cmd_q | term_rise;
   wire timer_done = (timer_q == {TW{1'b0}});
   // Stop request from software or a below-limit stop; stop mode picks the method for software, the tens digit for below-limit.
   wire bl_stop = below_edge && (below_limit_action_q[3:0] == 4'h1);
   wire do_ramp = stop_cmd_q ? ~stop_mode_select_q : bl_ramp;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= S_IDLE;
         timer_q <= {TW{1'b0}};
         prev_set_q <= 16'h0000;
         term_prev_q <= 1'b0;
         boot_q <= 1'b1;
      end else begin
         prev_set_q <= set_freq_q;
         term_prev_q <= run_terminal;
         if (tick_q && !timer_done) begin
            timer_q <= timer_q - {{(TW-1){1'b0}}, 1'b1};
         end
         case (state_q)
            S_IDLE: begin
               if (boot_q && init_done_q) begin
                  boot_q <= 1'b0;
                  if (power_loss_restart_enable_q && was_running_at_poweroff) begin
                     state_q <= S_RESTART;
                     timer_q <= restart_wait_time_q;
                  end else if (run_terminal && terminal_poweron_run_accept_q) begin
                     state_q <= S_START_DLY;
                     timer_q <= start_delay_time_q;
                  end else if (run_terminal) begin
                     state_q <= S_PROTECT;
                  end
               end else if (!boot_q && run_req) begin
                  state_q <= S_START_DLY;
                  timer_q <= start_delay_time_q;
               end
            end
            S_PROTECT: begin
               if (term_rise || run_cmd_q) begin
                  state_q <= S_START_DLY;
                  timer_q <= start_delay_time_q;
               end
            end
            S_RESTART: begin
               if (timer_done) begin
                  state_q <= S_START_DLY;
                  timer_q <= start_delay_time_q;
               end
            end
            S_START_DLY: begin
               if (stop_cmd_q) begin
                  state_q <= S_IDLE;
               end else if (timer_done) begin
                  state_q <= S_RUN;
               end
            end
            S_RUN, S_SLEEP: begin
               if (stop_cmd_q || bl_stop) begin
                  state_q <= do_ramp ? S_DECEL : S_COAST;
               end else if (below_edge && below_limit_action_q[3:0] == 4'h2) begin
                  state_q <= S_SLEEP;
               end else if (state_q == S_SLEEP && set_freq_q >= freq_lower_limit) begin
                  state_q <= S_RUN;
               end
            end
            S_DECEL: begin
               if (stop_brake_start_freq_q != 16'h0000) begin
                  if (ramp_freq < stop_brake_start_freq_q) begin
                     state_q <= S_DEMAG;
                     timer_q <= demag_wait_time_q;
                  end
               end else if (ramp_freq < stop_speed_threshold_q) begin
                  state_q <= S_SPD_DLY;
                  timer_q <= stop_speed_delay_q;
               end
            end
            S_DEMAG: begin
               if (timer_done) begin
                  if (short_brake_stop_hold_q != {TW{1'b0}}) begin
                     state_q <= S_SHORT;
                     timer_q <= short_brake_stop_hold_q;
                  end else if (stop_dc_brake_time_q != {TW{1'b0}}) begin
                     state_q <= S_DCB;
                     timer_q <= stop_dc_brake_time_q;
                  end else begin
                     state_q <= S_COAST;
                  end
               end
            end
            S_SHORT: begin
               if (timer_done) begin
                  if (stop_dc_brake_time_q != {TW{1'b0}}) begin
                     state_q <= S_DCB;
                     timer_q <= stop_dc_brake_time_q;
                  end else begin
                     state_q <= S_COAST;
                  end
               end
            end
            S_DCB: begin
               if (timer_done) begin
                  state_q <= S_COAST;
               end
            end
            S_SPD_DLY: begin
               if (timer_done) begin
                  if (!stop_detect_mode_q || det_speed_low) begin
                     state_q <= S_COAST;
                  end else begin
                     state_q <= S_DETECT;
                     timer_q <= stop_detect_time_q;
                  end
               end
            end
            S_DETECT: begin
               if (timer_done || det_speed_low) begin
                  state_q <= S_COAST;
               end
            end
            default: begin
               state_q <= S_IDLE;
            end
         endcase
      end
   end

   // ****************************************************************
   // Registered outputs
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         output_enable <= 1'b0;
         ramp_down <= 1'b0;
         short_brake_on <= 1'b0;
         dc_brake_on <= 1'b0;
         brake_current <= 12'h000;
         sleep_req <= 1'b0;
         hold_at_limit <= 1'b0;
         running <= 1'b0;
      end else begin
         // Output is blocked in demag, coast, delays and standby.
         output_enable <= (state_q == S_RUN) || (state_q == S_DECEL) ||
                          (state_q == S_SHORT) || (state_q == S_DCB);
         ramp_down <= (state_q == S_DECEL);
         short_brake_on <= (state_q == S_SHORT);
         dc_brake_on <= (state_q == S_DCB);
         brake_current <= (state_q == S_SHORT) ? short_brake_current_q
                          : (state_q == S_DCB) ? stop_dc_brake_current_q
                          : 12'h000;
         sleep_req <= (state_q == S_SLEEP);
         hold_at_limit <= (state_q == S_RUN) && (freq_lower_limit != 16'h0000) &&
                          (set_freq_q < freq_lower_limit) &&
                          (below_limit_action_q[3:0] == 4'h0);
         running <= (state_q == S_RUN) || (state_q == S_SLEEP);
      end
   end
endmodule // stop_restart_seq

// ### hw/stop_seq_regs.vh
// Register offsets, field positions, reset values and timing counts of the stop/restart sequencer.
`ifndef STOP_SEQ_REGS_VH
`define STOP_SEQ_REGS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_CTRL 12'h000
`define OFS_BRAKE_FREQ 12'h004
`define OFS_DEMAG 12'h008
`define OFS_DCB_TIME 12'h00c
`define OFS_SHORT_HOLD 12'h010
`define OFS_CURRENTS 12'h014
`define OFS_STOP_SPEED 12'h018
`define OFS_DET_TIME 12'h01c
`define OFS_SPD_DELAY 12'h020
`define OFS_RESTART_WAIT 12'h024
`define OFS_START_DELAY 12'h028
`define OFS_FREQ_IN 12'h02c
`define OFS_CMD 12'h030
`define OFS_STATUS 12'h034
// ****************************************************************
// Control and command register fields
// ****************************************************************
`define CTRL_STOP_MODE 0
`define CTRL_DET_MODE 1
`define CTRL_PLR_EN 2
`define CTRL_TERM_ACCEPT 3
`define CTRL_BLA_LO 8
`define CTRL_BLA_HI 15
`define CMD_RUN 0
`define CMD_STOP 1
`define CMD_INIT_DONE 2
// ****************************************************************
// Reset values
// ****************************************************************
`define RST_BLA 8'h00
`define RST_STOP_SPEED 16'h0032
`define RST_DET_TIME 20'h00032
`define RST_RESTART_WAIT 20'h00064
`define RST_DCB_CUR 12'h000
`define RST_SHORT_CUR 12'h000
// ****************************************************************
// Timing
// ****************************************************************
`define CLK_HZ 125000000
`define TICK_MS 10
`define TICK_CYCLES (`CLK_HZ / 1000 * `TICK_MS)
`endif

// ### tb/drive_stage_model.sv
// Behavioural model of the motor power stage feeding ramp and speed back to the sequencer.
`timescale 1ns/1ns
module drive_stage_model #(
   parameter [15:0] STEP = 16'h000a
) (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Commands from the sequencer and the target frequency
   input wire running,
   input wire output_enable,
   input wire ramp_down,
   input wire [15:0] target_freq,
   // Frequencies back to the sequencer
   output reg [15:0] ramp_freq,
   output reg [15:0] feedback_freq
);
   // ****************************************************************
   // Ramp and inertia
   // ****************************************************************
   // The shaft keeps turning after output is cut, so speed only decays by STEP per cycle.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_freq <= 16'h0000;
         feedback_freq <= 16'h0000;
      end else begin
         if (ramp_down)
            ramp_freq <= (ramp_freq > STEP) ? ramp_freq - STEP : 16'h0000;
         else if (running)
            ramp_freq <= target_freq;
         if (output_enable)
            feedback_freq <= ramp_freq;
         else
            feedback_freq <= (feedback_freq > STEP) ? feedback_freq - STEP : 16'h0000;
      end
   end
endmodule // drive_stage_model

// ### tb/stop_seq_properties.sv
// Concurrent checks on the ports of the stop and restart sequencer.
`timescale 1ns/1ns
module stop_seq_checker #(
   parameter TICK_CYCLES = 10,
   parameter TW = 20
) (
   // APB
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   // Power stage
   input wire output_enable,
   input wire ramp_down,
   input wire short_brake_on,
   input wire dc_brake_on,
   input wire [11:0] brake_current,
   input wire sleep_req,
   input wire hold_at_limit,
   input wire running
);
   // ****************************************************************
   // Helper state and properties
   // ****************************************************************
   // The stop mode is not visible at any power stage output, so it is tracked from bus writes.
   reg coast_q;
   wire done_wr = psel && penable && pready && pwrite;
   wire stop_wr = done_wr && paddr == 12'h030 && pwdata[1];
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         coast_q <= 1'b0;
      else if (done_wr && paddr == 12'h000)
         coast_q <= pwdata[0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_setup_answer; psel && !penable |=> pready; endproperty
   a_setup_answer: assert property (p_setup_answer) else $error("no answer after setup");
   property p_reset_quiet; $rose(presetn) |-> !output_enable && !running; endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
   property p_coast; stop_wr && coast_q |-> ##[1:4] !output_enable && !ramp_down; endproperty
   a_coast: assert property (p_coast) else $error("coast stop kept output");
   property p_ramp_enable; ramp_down |-> output_enable; endproperty
   a_ramp_enable: assert property (p_ramp_enable) else $error("ramp without output");
   property p_brakes_excl; short_brake_on |-> !dc_brake_on; endproperty
   a_brakes_excl: assert property (p_brakes_excl) else $error("both brakes on");
   property p_demag; $rose(short_brake_on || dc_brake_on) |-> !$past(output_enable); endproperty
   a_demag: assert property (p_demag) else $error("braking without blocked wait");
   property p_idle_current; !short_brake_on && !dc_brake_on |-> brake_current == 12'h000; endproperty
   a_idle_current: assert property (p_idle_current) else $error("current off brake");
   property p_hold_enable; hold_at_limit |-> output_enable && !ramp_down; endproperty
   a_hold_enable: assert property (p_hold_enable) else $error("hold without output");
   c_short: cover property (short_brake_on && brake_current != 12'h000);
   c_sleep: cover property (sleep_req);
   c_hold: cover property (hold_at_limit);
endmodule // stop_seq_checker

bind stop_restart_seq stop_seq_checker #(.TICK_CYCLES(TICK_CYCLES), .TW(TW)) props_i (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .output_enable(output_enable),
   .ramp_down(ramp_down), .short_brake_on(short_brake_on), .dc_brake_on(dc_brake_on),
   .brake_current(brake_current), .sleep_req(sleep_req), .hold_at_limit(hold_at_limit),
   .running(running));

// ### tb/tb_top.sv
// Self-checking bench for the stop, braking and power-on restart sequencer.
`timescale 1ns/1ns
`include "stop_seq_regs.vh"
module tb_top;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, clr;
   logic run_terminal, was_running_at_poweroff, output_enable, ramp_down, short_brake_on;
   logic dc_brake_on, sleep_req, hold_at_limit, running;
   logic [11:0] paddr, brake_current, short_cur;
   logic [31:0] pwdata, prdata, rdata;
   logic [15:0] ramp_freq, feedback_freq, freq_lower_limit;
   logic [6:0] outs, seen;
   int n_errors, cmp_count, waited;
   int acts[4] = '{8'h00, 8'h02, 8'h11, 8'h01};
   int bits[4] = '{5, 4, 1, 0};
   assign outs = {running, hold_at_limit, sleep_req, dc_brake_on, short_brake_on, ramp_down,
      output_enable};
   stop_restart_seq #(.TICK_CYCLES(10)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .run_terminal(run_terminal), .ramp_freq(ramp_freq), .feedback_freq(feedback_freq),
      .freq_lower_limit(freq_lower_limit), .was_running_at_poweroff(was_running_at_poweroff),
      .output_enable(output_enable), .ramp_down(ramp_down), .short_brake_on(short_brake_on),
      .dc_brake_on(dc_brake_on), .brake_current(brake_current), .sleep_req(sleep_req),
      .hold_at_limit(hold_at_limit), .running(running));
   drive_stage_model stage (.pclk(pclk), .presetn(presetn), .running(running),
      .output_enable(output_enable), .ramp_down(ramp_down), .target_freq(16'd2000),
      .ramp_freq(ramp_freq), .feedback_freq(feedback_freq));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Sticky record of outputs, so short pulses between polls are not missed.
   always @(posedge pclk) begin
      seen <= clr ? 7'h00 : (seen | outs);
      if (short_brake_on)
         short_cur <= brake_current;
   end
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task print_verdict;
      $display("errors %0d comparisons %0d", n_errors, cmp_count);
      if (n_errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         @(posedge pclk);
         n++;
      end
      chk("bus answer", pready, 1'b1);
      if (pready !== 1'b1)
         print_verdict;
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task wait_bit(input int i, input logic v, input int lim);
      waited = 0;
      while (outs[i] !== v && waited < lim) begin
         @(posedge pclk);
         waited++;
      end
      chk($sformatf("output %0d", i), outs[i], v);
      if (outs[i] !== v)
         print_verdict;
   endtask
   task do_reset(input logic rt, input logic was_on);
      presetn <= 1'b0;
      run_terminal <= rt;
      was_running_at_poweroff <= was_on;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask
   task stop_clr;
      clr <= 1'b1;
      wr(`OFS_CMD, 32'h2);
      clr <= 1'b0;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, presetn, clr} = '0;
      {run_terminal, was_running_at_poweroff, freq_lower_limit} = '0;
      n_errors = 0;
      cmp_count = 0;
      @(posedge pclk);
      do_reset(1'b0, 1'b0);
      chk("outputs after reset", outs, 0);
      apb(1'b0, `OFS_CTRL, 0);
      chk("ctrl reset", rdata, 0);
      apb(1'b0, 12'h040, 0);
      chk("unmapped data", rdata, 0);
      chk("unmapped error", rerr, 1);
      wr(`OFS_CMD, 32'h4);
      wr(`OFS_FREQ_IN, 32'd2000);
      wr(`OFS_START_DELAY, 32'd3);
      wr(`OFS_CMD, 32'h1);
      repeat (20) @(posedge pclk);
      chk("standby", output_enable, 0);
      wait_bit(0, 1'b1, 40);
      wr(`OFS_CTRL, 32'h1);
      stop_clr;
      wait_bit(0, 1'b0, 4);
      chk("coast ramp", seen[1], 0);
      wr(`OFS_CTRL, 32'h0);
      wr(`OFS_BRAKE_FREQ, 32'd100);
      wr(`OFS_DEMAG, 32'd2);
      wr(`OFS_DCB_TIME, 32'd2);
      wr(`OFS_CURRENTS, 32'h04b0_01f4);
      for (int k = 0; k < 2; k++) begin
         wr(`OFS_SHORT_HOLD, k ? 32'd0 : 32'd2);
         wr(`OFS_CMD, 32'h1);
         wait_bit(0, 1'b1, 60);
         stop_clr;
         wait_bit(1, 1'b1, 6);
         wait_bit(1, 1'b0, 400);
         chk("blocked wait", output_enable, 0);
         wait_bit(3, 1'b1, 100);
         chk("wait length", waited >= (k ? 10 : 30), 1);
         chk("short phase", seen[2], !k);
         if (k == 0)
            chk("short current", short_cur, 1200);
         chk("dc current", brake_current, 500);
         wait_bit(3, 1'b0, 60);
         chk("coast after dc", output_enable, 0);
      end
      wr(`OFS_BRAKE_FREQ, 32'd0);
      wr(`OFS_DET_TIME, 32'd3);
      for (int m = 0; m < 2; m++) begin
         wr(`OFS_CTRL, 32'(m << 1));
         wr(`OFS_CMD, 32'h1);
         wait_bit(0, 1'b1, 60);
         stop_clr;
         wait_bit(0, 1'b0, 400);
         chk("no braking", seen[3:2], 0);
      end
      for (int j = 0; j < 4; j++) begin
         do_reset(1'b0, 1'b0);
         freq_lower_limit <= 16'd1000;
         wr(`OFS_CMD, 32'h4);
         wr(`OFS_CTRL, 32'(acts[j] << 8));
         wr(`OFS_FREQ_IN, 32'd2000);
         wr(`OFS_CMD, 32'h1);
         wait_bit(0, 1'b1, 60);
         wr(`OFS_FREQ_IN, 32'd500);
         wait_bit(bits[j], bits[j] != 0, 20);
      end
      freq_lower_limit <= 16'd0;
      do_reset(1'b1, 1'b0);
      wr(`OFS_CMD, 32'h4);
      repeat (30) @(posedge pclk);
      chk("terminal ignored", output_enable, 0);
      run_terminal <= 1'b0;
      repeat (5) @(posedge pclk);
      run_terminal <= 1'b1;
      wait_bit(0, 1'b1, 60);
      do_reset(1'b1, 1'b0);
      wr(`OFS_CTRL, 32'h8);
      wr(`OFS_CMD, 32'h4);
      wait_bit(0, 1'b1, 60);
      do_reset(1'b0, 1'b1);
      wr(`OFS_CTRL, 32'h4);
      wr(`OFS_RESTART_WAIT, 32'd3);
      wr(`OFS_CMD, 32'h4);
      repeat (20) @(posedge pclk);
      chk("restart wait", output_enable, 0);
      wait_bit(0, 1'b1, 60);
      print_verdict;
   end
endmodule // tb_top
